// *** sfifo_pkg.sv ***
// Purpose: Shared constants and carriers for the serial FIFO threshold block
// Assumes: 32-bit APB register bus, byte addresses
// Notes: Offsets of all three registers are local choices

package sfifo_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] RX_QUEUE_CONFIG_OFS = 8'h00;
  localparam logic [7:0] TX_QUEUE_CONFIG_OFS = 8'h04;
  localparam logic [7:0] QUEUE_STATUS_OFS = 8'h08;
  localparam logic [31:0] CONFIG_RESET = 32'h00000000;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int FLUSH_BIT = 7;
  localparam int COND_BIT = 6;
  localparam int LVL_LSB = 0;
  localparam int ST_RX_LVL_LSB = 0;
  localparam int ST_TX_LVL_LSB = 8;

  // ----------------------------------------------------------------------
  // Partition sizes in bytes
  // ----------------------------------------------------------------------
  localparam logic [2:0] SIZE_HALF = 3'h4;
  localparam logic [2:0] SIZE_FULL = 3'h2;
  localparam logic [2:0] SIZE_NONE = 3'h0;

  typedef enum logic [1:0] {
    DPX_NONE,
    DPX_HALF_RX,
    DPX_HALF_TX,
    DPX_FULL
  } duplex_e;

  typedef struct packed {
    logic cond_sel;
    logic [1:0] level_sel;
  } queue_cfg_s;

  typedef struct packed {
    logic [2:0] fill;
    logic push;
    logic pop;
  } queue_ev_s;

endpackage

// *** serial_fifo_threshold_control.sv ***
// Purpose: Flush and threshold interrupt control for serial RX/TX FIFOs
// Assumes: FIFO storage outside; fill levels and push/pop from same clock
// Notes: No register write waits; pready is always high
//
// Summary of operation
// [RULE_01] Writing one to the receive flush bit empties the RX FIFO; the bit reads zero.
// [RULE_02] Writing one to the transmit flush bit empties the TX FIFO; the bit reads zero.
// [RULE_03] RX interrupt on reaching the threshold, or with select high also when fill exceeds it on a read.
// [RULE_04] TX interrupt on reaching the threshold, or with select high also when fill cannot reach it on a read.
// [RULE_05] TX threshold: half 0,1,2,3 bytes; full duplex 0,1,0,1 bytes.
// [RULE_06] Software flushes both FIFOs after choosing duplex and enabling the FIFOs.
// [RULE_07] Software rewrites the TX configuration after stopping the serial unit.
// [RULE_08] Software rewrites the TX configuration after waking from idle with idle run off.
// [RULE_09] RX threshold: half 4,1,2,3 bytes; full duplex 2,1,2,1 bytes.
// [RULE_10] Enabled FIFOs partition as 4 RX, 4 TX or 2 plus 2 by duplex mode.
//
// Our own choices: the APB interface to the registers and the register offsets.

module serial_fifo_threshold_control
  import sfifo_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic queue_enable,
  input wire duplex_e duplex_mode,
  input wire queue_ev_s rx_ev,
  input wire queue_ev_s tx_ev,
  output logic rx_flush,
  output logic tx_flush,
  output logic [2:0] rx_capacity,
  output logic [2:0] tx_capacity,
  output logic rx_irq,
  output logic tx_irq
);

  // ----------------------------------------------------------------------
  // Register access decode
  // ----------------------------------------------------------------------
  queue_cfg_s rx_cfg_reg, tx_cfg_reg;
  logic rx_flush_reg, tx_flush_reg;
  logic rx_irq_reg, tx_irq_reg;
  logic [2:0] rx_prev_reg, tx_prev_reg;
  logic [31:0] prdata_reg;

  wire access = psel && penable && clk_en;
  wire wr = access && pwrite;
  // Read data loads at the setup edge so it stands in the access phase
  wire rd = psel && !penable && !pwrite && clk_en;
  wire hit_rx = (paddr == RX_QUEUE_CONFIG_OFS);
  wire hit_tx = (paddr == TX_QUEUE_CONFIG_OFS);
  wire hit_st = (paddr == QUEUE_STATUS_OFS);
  wire unmapped = !(hit_rx || hit_tx || hit_st);
  wire wr_rx = wr && hit_rx;
  wire wr_tx = wr && hit_tx;
  wire is_full = (duplex_mode == DPX_FULL);

  assign pready = 1'b1;
  // Unmapped or status writes flag an error; state is untouched
  assign pslverr = psel && penable && (unmapped || (pwrite && hit_st));

  // Flush bit never stored: read value carries zero at bit 7
  wire [31:0] rx_rd = {24'h0, 1'b0, rx_cfg_reg.cond_sel, 4'h0,
                       rx_cfg_reg.level_sel}; // see [RULE_01]
  wire [31:0] tx_rd = {24'h0, 1'b0, tx_cfg_reg.cond_sel, 4'h0,
                       tx_cfg_reg.level_sel}; // see [RULE_02]
  wire [31:0] st_rd = {16'h0, 2'h0, tx_irq_reg, 2'h0, tx_ev.fill,
                       2'h0, rx_irq_reg, 2'h0, rx_ev.fill};
  wire [31:0] rd_mux = hit_rx ? rx_rd : hit_tx ? tx_rd :
                       hit_st ? st_rd : 32'h00000000;

  assign prdata = prdata_reg;

  // ----------------------------------------------------------------------
  // Partitioning
  // ----------------------------------------------------------------------
  // see [RULE_10]
  assign rx_capacity = !queue_enable ? SIZE_NONE :
                       is_full ? SIZE_FULL :
                       (duplex_mode == DPX_HALF_RX) ? SIZE_HALF : SIZE_NONE;
  assign tx_capacity = !queue_enable ? SIZE_NONE :
                       is_full ? SIZE_FULL :
                       (duplex_mode == DPX_HALF_TX) ? SIZE_HALF : SIZE_NONE;

  // ----------------------------------------------------------------------
  // Thresholds
  // ----------------------------------------------------------------------
  logic [2:0] rx_thr, tx_thr;
  always_comb begin
    // see [RULE_09]
    case (rx_cfg_reg.level_sel)
      2'h0: rx_thr = is_full ? 3'h2 : 3'h4;
      2'h1: rx_thr = 3'h1;
      2'h2: rx_thr = 3'h2;
      default: rx_thr = is_full ? 3'h1 : 3'h3;
    endcase
    // see [RULE_05]
    if (is_full) begin
      tx_thr = {2'h0, tx_cfg_reg.level_sel[0]};
    end else begin
      tx_thr = {1'b0, tx_cfg_reg.level_sel};
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt conditions
  // ----------------------------------------------------------------------
  // RX reach: fill steps onto the threshold from any other level, below or above
  wire rx_reach = (rx_ev.fill == rx_thr) && (rx_prev_reg != rx_thr);
  wire rx_read_hit = rx_cfg_reg.cond_sel && rx_ev.pop &&
                     (rx_ev.fill > rx_thr); // see [RULE_03]
  wire rx_fire = queue_enable && (rx_reach || rx_read_hit); // see [RULE_03]
  // TX reach: fill steps onto the threshold from any other level, above or below
  wire tx_reach = (tx_ev.fill == tx_thr) && (tx_prev_reg != tx_thr);
  wire tx_read_hit = tx_cfg_reg.cond_sel && tx_ev.pop &&
                     (tx_ev.fill < tx_thr); // see [RULE_04]
  wire tx_fire = queue_enable && (tx_reach || tx_read_hit); // see [RULE_04]

  assign rx_flush = rx_flush_reg;
  assign tx_flush = tx_flush_reg;
  assign rx_irq = rx_irq_reg;
  assign tx_irq = tx_irq_reg;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_cfg_reg <= queue_cfg_s'(CONFIG_RESET[2:0]);
      tx_cfg_reg <= queue_cfg_s'(CONFIG_RESET[2:0]);
      prdata_reg <= CONFIG_RESET;
    end else if (clk_en) begin
      if (wr_rx) begin
        rx_cfg_reg <= {pwdata[COND_BIT], pwdata[LVL_LSB +: 2]};
      end
      if (wr_tx) begin
        tx_cfg_reg <= {pwdata[COND_BIT], pwdata[LVL_LSB +: 2]};
      end
      if (rd) begin
        prdata_reg <= rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_flush_reg <= 1'b0;
      tx_flush_reg <= 1'b0;
      rx_irq_reg <= 1'b0;
      tx_irq_reg <= 1'b0;
      rx_prev_reg <= 3'h0;
      tx_prev_reg <= 3'h0;
    end else if (clk_en) begin
      rx_flush_reg <= wr_rx && pwdata[FLUSH_BIT]; // see [RULE_01]
      tx_flush_reg <= wr_tx && pwdata[FLUSH_BIT]; // see [RULE_02]
      rx_irq_reg <= rx_fire;
      tx_irq_reg <= tx_fire;
      rx_prev_reg <= rx_ev.fill;
      tx_prev_reg <= tx_ev.fill;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_RX_FLUSH_PULSE: assert property ( // see [RULE_01]
    @(posedge pclk) disable iff (!presetn)
    (clk_en && wr_rx && pwdata[FLUSH_BIT]) |=> rx_flush)
    else $error("rx flush pulse missing");

  AST_TX_FLUSH_PULSE: assert property ( // see [RULE_02]
    @(posedge pclk) disable iff (!presetn)
    (clk_en && wr_tx && pwdata[FLUSH_BIT]) |=> tx_flush)
    else $error("tx flush pulse missing");

  AST_FLUSH_ONE_CYCLE: assert property ( // see [RULE_01]
    @(posedge pclk) disable iff (!presetn)
    (rx_flush && clk_en && !wr_rx) |=> !rx_flush)
    else $error("rx flush stuck");

  AST_RX_READS_ZERO: assert property ( // see [RULE_01]
    @(posedge pclk) disable iff (!presetn)
    (clk_en && rd && hit_rx) |=> !prdata[FLUSH_BIT])
    else $error("rx flush bit read as one");

  AST_TX_READS_ZERO: assert property ( // see [RULE_02]
    @(posedge pclk) disable iff (!presetn)
    (clk_en && rd && hit_tx) |=> !prdata[FLUSH_BIT])
    else $error("tx flush bit read as one");

  AST_RX_READ_IRQ: assert property ( // see [RULE_03]
    @(posedge pclk) disable iff (!presetn)
    (clk_en && queue_enable && rx_cfg_reg.cond_sel && rx_ev.pop &&
     rx_ev.fill > rx_thr) |=> rx_irq)
    else $error("rx read interrupt missing");

  AST_RX_NO_SEL: assert property ( // see [RULE_03]
    @(posedge pclk) disable iff (!presetn)
    (clk_en && !rx_cfg_reg.cond_sel && rx_ev.fill != rx_thr) |=> !rx_irq)
    else $error("rx interrupt off threshold");

  AST_TX_READ_IRQ: assert property ( // see [RULE_04]
    @(posedge pclk) disable iff (!presetn)
    (clk_en && queue_enable && tx_cfg_reg.cond_sel && tx_ev.pop &&
     tx_ev.fill < tx_thr) |=> tx_irq)
    else $error("tx read interrupt missing");

  AST_TX_FULL_THR: assert property ( // see [RULE_05]
    @(posedge pclk) disable iff (!presetn)
    (is_full && tx_cfg_reg.level_sel == 2'h2) |-> tx_thr == 3'h0)
    else $error("tx full duplex threshold wrong");

  AST_RX_HALF_THR: assert property ( // see [RULE_09]
    @(posedge pclk) disable iff (!presetn)
    (!is_full && rx_cfg_reg.level_sel == 2'h0) |-> rx_thr == 3'h4)
    else $error("rx half duplex threshold wrong");

  AST_PARTITION: assert property ( // see [RULE_10]
    @(posedge pclk) disable iff (!presetn)
    (queue_enable && is_full) |-> (rx_capacity == 3'h2 &&
     tx_capacity == 3'h2))
    else $error("full duplex partition wrong");

endmodule

// *** serial_fifo_threshold_control_bench.sv ***
// Purpose: Self-checking bench for the serial FIFO threshold block
// Assumes: zero-wait APB slave, irq one cycle after its cause
// Notes: clk_en dropped once to show that a frozen block ignores writes
module serial_fifo_threshold_control_bench import sfifo_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic queue_enable, rx_flush, tx_flush, rx_irq, tx_irq, err, clk_en;
  logic rf_now, tf_now, rf_after, tf_after;
  logic [2:0] rx_capacity, tx_capacity;
  duplex_e duplex_mode;
  queue_ev_s rx_ev, tx_ev;
  int n_errors = 0;
  int total_checks = 0;
  // Index: direction, full duplex, level field
  logic [2:0] thr_tbl [2][2][4] = '{'{'{3'h4, 3'h1, 3'h2, 3'h3},
    '{3'h2, 3'h1, 3'h2, 3'h1}}, '{'{3'h0, 3'h1, 3'h2, 3'h3},
    '{3'h0, 3'h1, 3'h0, 3'h1}}};

  serial_fifo_threshold_control dut_u (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .queue_enable(queue_enable),
    .duplex_mode(duplex_mode), .rx_ev(rx_ev), .tx_ev(tx_ev),
    .rx_flush(rx_flush), .tx_flush(tx_flush), .rx_capacity(rx_capacity),
    .tx_capacity(tx_capacity), .rx_irq(rx_irq), .tx_irq(tx_irq));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Access and check tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Flush outputs are caught in the cycle after the access edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    // Taken at the ready edge, before the design's own updates land
    if (pready !== 1'b1) n_errors++;
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    #1 rf_now = rx_flush;
    tf_now = tx_flush;
    @(posedge pclk);
    #1 rf_after = rx_flush;
    tf_after = tx_flush;
  endtask

  task automatic set_ev(input int t, input logic [2:0] f, input logic p);
    if (t == 1) tx_ev <= '{fill: f, push: 1'b0, pop: p};
    else rx_ev <= '{fill: f, push: 1'b0, pop: p};
  endtask

  // Settle on f0, step to f1 with optional pop, count irq pulses
  task automatic reach(input int t, input logic [2:0] f0,
                       input logic [2:0] f1, input logic p, output int cnt);
    cnt = 0;
    @(posedge pclk);
    set_ev(t, f0, 1'b0);
    repeat (3) @(posedge pclk);
    set_ev(t, f1, p);
    @(posedge pclk);
    set_ev(t, f1, 1'b0);
    repeat (4) begin
      #1 cnt += int'((t == 1 ? tx_irq : rx_irq) === 1'b1);
      @(posedge pclk);
    end
  endtask

  task automatic complete_run;
    $display("Checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    int cnt;
    logic [2:0] thr;
    logic [7:0] ofs;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    queue_enable = 1'b0;
    clk_en = 1'b1;
    duplex_mode = DPX_FULL;
    rx_ev = '0;
    tx_ev = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    #1 check("rx_cap_off", rx_capacity, SIZE_NONE);
    for (int t = 0; t < 2; t++) begin
      ofs = t == 1 ? TX_QUEUE_CONFIG_OFS : RX_QUEUE_CONFIG_OFS;
      apb(1'b0, ofs, 32'h0);
      check("cfg_reset", rd, CONFIG_RESET);
      apb(1'b1, ofs, 32'hFFFFFFC5);
      check("rx_flush_now", rf_now, t == 0);
      check("tx_flush_now", tf_now, t == 1);
      check("flush_after", {rf_after, tf_after}, 2'b00);
      apb(1'b0, ofs, 32'h0);
      check("cfg_read", rd, 32'h41);
    end
    apb(1'b0, 8'h0C, 32'h0);
    check("unmapped_err", err, 1'b1);
    check("unmapped_rd", rd, 32'h0);
    apb(1'b1, QUEUE_STATUS_OFS, 32'h0);
    check("status_wr_err", err, 1'b1);
    // Frozen block: the write is dropped and no flush pulse leaves
    @(posedge pclk);
    clk_en <= 1'b0;
    apb(1'b1, RX_QUEUE_CONFIG_OFS, 32'h00000082);
    check("frozen_flush", rf_now, 1'b0);
    @(posedge pclk);
    clk_en <= 1'b1;
    apb(1'b0, RX_QUEUE_CONFIG_OFS, 32'h0);
    check("frozen_cfg", rd, 32'h41);
    apb(1'b1, TX_QUEUE_CONFIG_OFS, 32'h41);
    @(posedge pclk);
    queue_enable <= 1'b1;
    apb(1'b1, RX_QUEUE_CONFIG_OFS, 32'h80);
    check("rx_flush_init", rf_now, 1'b1);
    apb(1'b1, TX_QUEUE_CONFIG_OFS, 32'h80);
    check("tx_flush_init", tf_now, 1'b1);
    for (int t = 0; t < 2; t++)
      for (int m = 0; m < 2; m++)
        for (int l = 0; l < 4; l++) begin
          @(posedge pclk);
          duplex_mode <= m == 1 ? DPX_FULL :
                         (t == 1 ? DPX_HALF_TX : DPX_HALF_RX);
          thr = thr_tbl[t][m][l];
          ofs = t == 1 ? TX_QUEUE_CONFIG_OFS : RX_QUEUE_CONFIG_OFS;
          apb(1'b1, ofs, 32'(l));
          check("capacity", t == 1 ? tx_capacity : rx_capacity,
                m == 1 ? SIZE_FULL : SIZE_HALF);
          reach(t, t == 1 ? 3'(thr + 3'h1) : 3'(thr - 3'h1), thr, 1'b0,
                cnt);
          check("level_irq", cnt, 1);
        end
    for (int c = 0; c < 2; c++)
      for (int t = 0; t < 2; t++) begin
        @(posedge pclk);
        duplex_mode <= t == 1 ? DPX_HALF_TX : DPX_HALF_RX;
        ofs = t == 1 ? TX_QUEUE_CONFIG_OFS : RX_QUEUE_CONFIG_OFS;
        apb(1'b1, ofs, 32'(c * 64 + (t == 1 ? 3 : 1)));
        thr = t == 1 ? 3'h1 : 3'h3;
        reach(t, thr, thr, 1'b1, cnt);
        check("read_irq", cnt, c);
      end
    apb(1'b0, QUEUE_STATUS_OFS, 32'h0);
    check("status_rd", rd, 32'h00000103);
    complete_run;
  end

  initial begin
    #20000;
    n_errors++;
    complete_run;
  end
endmodule
